// File: core/asf_pkg.sv
// constants for the audio serial fifo status and trigger block
package asf_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [11:0] ASF_OFF_CONFIG   = 12'hE00;
   localparam logic [11:0] ASF_OFF_STATUS   = 12'hE04;
   localparam logic [11:0] ASF_OFF_TRIGGER  = 12'hE08;
   localparam logic [11:0] ASF_OFF_IRQ_SET  = 12'hE10;
   localparam logic [11:0] ASF_OFF_IRQ_CLR  = 12'hE14;
   localparam logic [11:0] ASF_OFF_IRQ_STAT = 12'hE18;
   // ==========================================================
   // fifo_status fields
   localparam int ASF_ST_TX_FAULT   = 0;
   localparam int ASF_ST_RX_OVERRUN = 1;
   localparam int ASF_ST_PERIPH_IRQ = 3;
   localparam int ASF_ST_TX_DRAINED = 4;
   localparam int ASF_ST_TX_ROOM    = 5;
   localparam int ASF_ST_RX_ENTRY   = 6;
   localparam int ASF_ST_RX_FULL    = 7;
   localparam int ASF_ST_TX_LVL_LO  = 8;
   localparam int ASF_ST_RX_LVL_LO  = 16;
   // ==========================================================
   // fifo_trigger_settings fields
   localparam int ASF_TR_TX_ON      = 0;
   localparam int ASF_TR_RX_ON      = 1;
   localparam int ASF_TR_TX_PT_LO   = 8;
   localparam int ASF_TR_RX_PT_LO   = 16;
   localparam int ASF_PT_W          = 4;
   // ==========================================================
   // fifo_config fields
   localparam int ASF_CF_DMA_TX     = 12;
   localparam int ASF_CF_DMA_RX     = 13;
   localparam int ASF_CF_WAKE_TX    = 14;
   localparam int ASF_CF_WAKE_RX    = 15;
   localparam int ASF_CF_FLUSH_TX   = 16;
   localparam int ASF_CF_FLUSH_RX   = 17;
   // ==========================================================
   // interrupt enable / status fields
   localparam int ASF_IE_TX_FAULT   = 0;
   localparam int ASF_IE_RX_OVERRUN = 1;
   localparam int ASF_IE_TX_LEVEL   = 2;
   localparam int ASF_IE_RX_LEVEL   = 3;
   localparam int ASF_IE_PERIPH     = 4;
   localparam int ASF_IE_W          = 4;
   // ==========================================================
   // sizes and reset values
   localparam int ASF_DEPTH         = 8;
   localparam int ASF_CNT_W         = 5;
   localparam logic [3:0] ASF_PT_RST   = 4'h0;
   localparam logic [3:0] ASF_IE_RST   = 4'h0;
   localparam logic [4:0] ASF_CNT_RST  = 5'h00;
   localparam logic [31:0] ASF_RD_ZERO = 32'h0000_0000;
endpackage : asf_pkg

// File: core/asf_fifo_status.sv
// status, level trigger and dma request logic of an audio serial fifo
// ==========================================================
// Summary of operation
// - tx fault flag: push when full or pop when empty; write one clears
// - rx overrun flag: peripheral push into full rx fifo; write one clears
// - status bit mirrors the peripheral interrupt request
// - tx drained reads one when tx fifo empty, resets to one
// - tx has room resets to one, zero only when tx fifo full
// - rx has entry is one when rx fifo holds data, resets zero
// - rx at capacity is one when rx fifo full, resets zero
// - five-bit tx level field shows current tx entry count
// - five-bit rx level field shows current rx entry count
// - tx flags always agree with tx count
// - rx flags always agree with rx count
// - tx level trigger only when enabled; interrupt needs its enable too
// - rx level trigger only when enabled; interrupt needs its enable too
// - dma requests ignore the level trigger enables
// - tx trigger point N fires when tx level decreases to N
// - rx trigger point N fires when rx fifo holds N+1 entries
// - rx trigger compared when a new item enters rx fifo
// - trigger point ignored unless its trigger enable is set
// - reached level may request a wake for dma service
// - both directions in one instance; tx and rx sides kept independent
// - tx dma request while enabled and tx fifo not full
// - rx dma request while enabled and rx fifo not empty
// - tx level interrupt needs trigger enable, irq enable and level reached
`timescale 1ns/1ps
`default_nettype none
module asf_fifo_status #(
   parameter int DEPTH = asf_pkg::ASF_DEPTH,
   parameter int CNT_W = asf_pkg::ASF_CNT_W
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tx_push,
   input  wire logic        tx_pop,
   input  wire logic        rx_push,
   input  wire logic        rx_pop,
   input  wire logic        periph_irq,
   output logic             tx_dma_req,
   output logic             rx_dma_req,
   output logic             tx_level_trig,
   output logic             rx_level_trig,
   output logic             fifo_irq,
   output logic             wake_req
);
   // ==========================================================
   // parameter checks
   // level fields are five bits wide, trigger points four
   if (CNT_W != asf_pkg::ASF_CNT_W) begin : g_bad_cnt_w
      $error("asf_fifo_status: CNT_W must match the level field width");
   end
   if (DEPTH < 1 || DEPTH >= (1 << CNT_W)) begin : g_bad_depth
      $error("asf_fifo_status: DEPTH does not fit the level field");
   end
   if (DEPTH > (1 << asf_pkg::ASF_PT_W)) begin : g_bad_point
      $error("asf_fifo_status: trigger points cannot reach DEPTH");
   end

   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   // ==========================================================
   // state
   typedef struct packed {
      logic [CNT_W-1:0]               tx_cnt;
      logic [CNT_W-1:0]               rx_cnt;
      logic                           tx_fault_flag;
      logic                           rx_overrun_flag;
      logic                           tx_hit;
      logic                           rx_hit;
      logic                           tx_dma_request_on;
      logic                           rx_dma_request_on;
      logic                           tx_wake_on;
      logic                           rx_wake_on;
      logic                           tx_level_trigger_on;
      logic                           rx_level_trigger_on;
      logic [asf_pkg::ASF_PT_W-1:0]   tx_point;
      logic [asf_pkg::ASF_PT_W-1:0]   rx_point;
      logic [asf_pkg::ASF_IE_W-1:0]   irq_enable;
      logic [31:0]                    rdata;
      logic                           slverr;
   } asf_state_s;

   asf_state_s s_r;
   asf_state_s s_nxt;

   // ==========================================================
   // combinational views
   logic                           setup_ph;
   logic                           wr_acc;
   logic                           mapped;
   logic                           tx_full;
   logic                           tx_empty;
   logic                           rx_full;
   logic                           rx_empty;
   logic                           tx_push_ok;
   logic                           tx_pop_ok;
   logic                           rx_push_ok;
   logic                           rx_pop_ok;
   logic                           tx_trig;
   logic                           rx_trig;
   logic                           tx_fault_evt;
   logic                           rx_overrun_evt;
   logic [asf_pkg::ASF_IE_W:0]     irq_stat;
   logic [31:0]                    status_word;
   logic [31:0]                    trig_word;
   logic [31:0]                    cfg_word;
   logic [31:0]                    rd_word;

   always_comb begin
      setup_ph = psel && !penable;
      wr_acc   = psel && penable && pwrite;
      mapped   = (paddr == asf_pkg::ASF_OFF_CONFIG)  ||
                 (paddr == asf_pkg::ASF_OFF_STATUS)  ||
                 (paddr == asf_pkg::ASF_OFF_TRIGGER) ||
                 (paddr == asf_pkg::ASF_OFF_IRQ_SET) ||
                 (paddr == asf_pkg::ASF_OFF_IRQ_CLR) ||
                 (paddr == asf_pkg::ASF_OFF_IRQ_STAT);

      // flags derived straight from the counts
      tx_full  = (s_r.tx_cnt == FULL_CNT);
      tx_empty = (s_r.tx_cnt == '0);
      rx_full  = (s_r.rx_cnt == FULL_CNT);
      rx_empty = (s_r.rx_cnt == '0);

      // each side runs on its own, both can be used in one instance
      // a push into a full fifo still fits when a pop leaves in the same cycle
      tx_push_ok = tx_push && (!tx_full || tx_pop);
      tx_pop_ok  = tx_pop && !tx_empty;
      rx_push_ok = rx_push && (!rx_full || rx_pop);
      rx_pop_ok  = rx_pop && !rx_empty;

      // overflow, or the peripheral asking an empty tx fifo for data
      tx_fault_evt   = (tx_push && tx_full && !tx_pop) || (tx_pop && tx_empty);
      rx_overrun_evt = rx_push && rx_full && !rx_pop;

      // trigger points only count when enabled
      tx_trig = s_r.tx_level_trigger_on && s_r.tx_hit;
      rx_trig = s_r.rx_level_trigger_on && s_r.rx_hit;

      irq_stat = '0;
      irq_stat[asf_pkg::ASF_IE_TX_FAULT] =
         s_r.tx_fault_flag && s_r.irq_enable[asf_pkg::ASF_IE_TX_FAULT];
      irq_stat[asf_pkg::ASF_IE_RX_OVERRUN] =
         s_r.rx_overrun_flag && s_r.irq_enable[asf_pkg::ASF_IE_RX_OVERRUN];
      irq_stat[asf_pkg::ASF_IE_TX_LEVEL] =
         tx_trig && s_r.irq_enable[asf_pkg::ASF_IE_TX_LEVEL];
      irq_stat[asf_pkg::ASF_IE_RX_LEVEL] =
         rx_trig && s_r.irq_enable[asf_pkg::ASF_IE_RX_LEVEL];
      irq_stat[asf_pkg::ASF_IE_PERIPH] = periph_irq;

      // status word, reserved bits zero
      status_word = asf_pkg::ASF_RD_ZERO;
      status_word[asf_pkg::ASF_ST_TX_FAULT]   = s_r.tx_fault_flag;
      status_word[asf_pkg::ASF_ST_RX_OVERRUN] = s_r.rx_overrun_flag;
      status_word[asf_pkg::ASF_ST_PERIPH_IRQ] = periph_irq;
      status_word[asf_pkg::ASF_ST_TX_DRAINED] = tx_empty;
      status_word[asf_pkg::ASF_ST_TX_ROOM]    = !tx_full;
      status_word[asf_pkg::ASF_ST_RX_ENTRY]   = !rx_empty;
      status_word[asf_pkg::ASF_ST_RX_FULL]    = rx_full;
      status_word[asf_pkg::ASF_ST_TX_LVL_LO +: CNT_W] = s_r.tx_cnt;
      status_word[asf_pkg::ASF_ST_RX_LVL_LO +: CNT_W] = s_r.rx_cnt;

      trig_word = asf_pkg::ASF_RD_ZERO;
      trig_word[asf_pkg::ASF_TR_TX_ON] = s_r.tx_level_trigger_on;
      trig_word[asf_pkg::ASF_TR_RX_ON] = s_r.rx_level_trigger_on;
      trig_word[asf_pkg::ASF_TR_TX_PT_LO +: asf_pkg::ASF_PT_W] = s_r.tx_point;
      trig_word[asf_pkg::ASF_TR_RX_PT_LO +: asf_pkg::ASF_PT_W] = s_r.rx_point;

      cfg_word = asf_pkg::ASF_RD_ZERO;
      cfg_word[asf_pkg::ASF_CF_DMA_TX]  = s_r.tx_dma_request_on;
      cfg_word[asf_pkg::ASF_CF_DMA_RX]  = s_r.rx_dma_request_on;
      cfg_word[asf_pkg::ASF_CF_WAKE_TX] = s_r.tx_wake_on;
      cfg_word[asf_pkg::ASF_CF_WAKE_RX] = s_r.rx_wake_on;

      // read mux
      rd_word = asf_pkg::ASF_RD_ZERO;
      unique case (paddr)
         asf_pkg::ASF_OFF_CONFIG:   rd_word = cfg_word;
         asf_pkg::ASF_OFF_STATUS:   rd_word = status_word;
         asf_pkg::ASF_OFF_TRIGGER:  rd_word = trig_word;
         asf_pkg::ASF_OFF_IRQ_SET:  rd_word[asf_pkg::ASF_IE_W-1:0] = s_r.irq_enable;
         asf_pkg::ASF_OFF_IRQ_CLR:  rd_word[asf_pkg::ASF_IE_W-1:0] = s_r.irq_enable;
         asf_pkg::ASF_OFF_IRQ_STAT: rd_word[asf_pkg::ASF_IE_W:0] = irq_stat;
         default:                   rd_word = asf_pkg::ASF_RD_ZERO;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      s_nxt = s_r;

      // apb read data and error captured in setup phase
      if (setup_ph) begin
         s_nxt.rdata  = pwrite ? asf_pkg::ASF_RD_ZERO : rd_word;
         s_nxt.slverr = !mapped;
      end

      // fill counts
      s_nxt.tx_cnt = s_r.tx_cnt + CNT_W'(tx_push_ok) - CNT_W'(tx_pop_ok);
      s_nxt.rx_cnt = s_r.rx_cnt + CNT_W'(rx_push_ok) - CNT_W'(rx_pop_ok);

      // register writes; reserved bits are dropped
      if (wr_acc) begin
         unique case (paddr)
            asf_pkg::ASF_OFF_CONFIG: begin
               s_nxt.tx_dma_request_on = pwdata[asf_pkg::ASF_CF_DMA_TX];
               s_nxt.rx_dma_request_on = pwdata[asf_pkg::ASF_CF_DMA_RX];
               s_nxt.tx_wake_on        = pwdata[asf_pkg::ASF_CF_WAKE_TX];
               s_nxt.rx_wake_on        = pwdata[asf_pkg::ASF_CF_WAKE_RX];
               if (pwdata[asf_pkg::ASF_CF_FLUSH_TX]) begin
                  s_nxt.tx_cnt = asf_pkg::ASF_CNT_RST;
               end
               if (pwdata[asf_pkg::ASF_CF_FLUSH_RX]) begin
                  s_nxt.rx_cnt = asf_pkg::ASF_CNT_RST;
               end
            end
            asf_pkg::ASF_OFF_STATUS: begin
               if (pwdata[asf_pkg::ASF_ST_TX_FAULT]) begin
                  s_nxt.tx_fault_flag = 1'b0;
               end
               if (pwdata[asf_pkg::ASF_ST_RX_OVERRUN]) begin
                  s_nxt.rx_overrun_flag = 1'b0;
               end
            end
            asf_pkg::ASF_OFF_TRIGGER: begin
               s_nxt.tx_level_trigger_on = pwdata[asf_pkg::ASF_TR_TX_ON];
               s_nxt.rx_level_trigger_on = pwdata[asf_pkg::ASF_TR_RX_ON];
               s_nxt.tx_point = pwdata[asf_pkg::ASF_TR_TX_PT_LO +: asf_pkg::ASF_PT_W];
               s_nxt.rx_point = pwdata[asf_pkg::ASF_TR_RX_PT_LO +: asf_pkg::ASF_PT_W];
            end
            asf_pkg::ASF_OFF_IRQ_SET: begin
               s_nxt.irq_enable = s_r.irq_enable | pwdata[asf_pkg::ASF_IE_W-1:0];
            end
            asf_pkg::ASF_OFF_IRQ_CLR: begin
               s_nxt.irq_enable = s_r.irq_enable & ~pwdata[asf_pkg::ASF_IE_W-1:0];
            end
            default: begin
               s_nxt.irq_enable = s_r.irq_enable;
            end
         endcase
      end

      // error events win over a same-cycle clear
      if (tx_fault_evt) begin
         s_nxt.tx_fault_flag = 1'b1;
      end
      if (rx_overrun_evt) begin
         s_nxt.rx_overrun_flag = 1'b1;
      end

      // tx level: set when the count falls to the point, cleared on rising above
      // points are taken as they stand after this edge
      if (s_nxt.tx_cnt < s_r.tx_cnt &&
          s_nxt.tx_cnt <= {1'b0, s_nxt.tx_point}) begin
         s_nxt.tx_hit = 1'b1;
      end else if (s_nxt.tx_cnt > {1'b0, s_nxt.tx_point}) begin
         s_nxt.tx_hit = 1'b0;
      end

      // rx level: checked as an item arrives, cleared once it drains back to the point
      if (rx_push_ok && s_nxt.rx_cnt > {1'b0, s_nxt.rx_point}) begin
         s_nxt.rx_hit = 1'b1;
      end else if (s_nxt.rx_cnt <= {1'b0, s_nxt.rx_point}) begin
         s_nxt.rx_hit = 1'b0;
      end

      // a disabled trigger keeps no stale hit that would fire on enable
      if (!s_nxt.tx_level_trigger_on) begin
         s_nxt.tx_hit = 1'b0;
      end
      if (!s_nxt.rx_level_trigger_on) begin
         s_nxt.rx_hit = 1'b0;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.tx_cnt              <= asf_pkg::ASF_CNT_RST;
         s_r.rx_cnt              <= asf_pkg::ASF_CNT_RST;
         s_r.tx_fault_flag       <= 1'b0;
         s_r.rx_overrun_flag     <= 1'b0;
         s_r.tx_hit              <= 1'b0;
         s_r.rx_hit              <= 1'b0;
         s_r.tx_dma_request_on   <= 1'b0;
         s_r.rx_dma_request_on   <= 1'b0;
         s_r.tx_wake_on          <= 1'b0;
         s_r.rx_wake_on          <= 1'b0;
         s_r.tx_level_trigger_on <= 1'b0;
         s_r.rx_level_trigger_on <= 1'b0;
         s_r.tx_point            <= asf_pkg::ASF_PT_RST;
         s_r.rx_point            <= asf_pkg::ASF_PT_RST;
         s_r.irq_enable          <= asf_pkg::ASF_IE_RST;
         s_r.rdata               <= asf_pkg::ASF_RD_ZERO;
         s_r.slverr              <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs
   always_comb begin
      prdata        = s_r.rdata;
      pready        = 1'b1;
      pslverr       = psel && penable && s_r.slverr;
      tx_dma_req    = s_r.tx_dma_request_on && !tx_full;
      rx_dma_req    = s_r.rx_dma_request_on && !rx_empty;
      tx_level_trig = tx_trig;
      rx_level_trig = rx_trig;
      fifo_irq      = |irq_stat;
      wake_req      = (s_r.tx_wake_on && tx_trig) ||
                      (s_r.rx_wake_on && rx_trig);
   end
endmodule : asf_fifo_status
`default_nettype wire

// File: verification/asf_fifo_status_props.sv
// assertion checker for the fifo status block
`timescale 1ns/1ps
`default_nettype none
module asf_fifo_status_props #(
   parameter int DEPTH = 8,
   parameter int CNT_W = 5
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tx_push,
   input wire logic        tx_pop,
   input wire logic        rx_push,
   input wire logic        rx_pop,
   input wire logic        periph_irq,
   input wire logic        tx_dma_req,
   input wire logic        rx_dma_req,
   input wire logic        tx_level_trig,
   input wire logic        rx_level_trig,
   input wire logic        fifo_irq,
   input wire logic        wake_req
);
   // ==========================================================
   // shadow counts and trigger settings
   logic [CNT_W-1:0] tx_cnt_r;
   logic [CNT_W-1:0] rx_cnt_r;
   logic [31:0]      trig_r;
   logic             wr_acc;
   logic             rd_st;
   assign wr_acc = psel && penable && pwrite;
   assign rd_st  = psel && penable && !pwrite && paddr == asf_pkg::ASF_OFF_STATUS;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt_r <= '0;
         rx_cnt_r <= '0;
         trig_r   <= '0;
      end else begin
         if (wr_acc && paddr == asf_pkg::ASF_OFF_TRIGGER) trig_r <= pwdata;
         if (wr_acc && paddr == asf_pkg::ASF_OFF_CONFIG && pwdata[16]) tx_cnt_r <= '0;
         else tx_cnt_r <= tx_cnt_r + CNT_W'(tx_push && (tx_cnt_r != DEPTH || tx_pop))
                                   - CNT_W'(tx_pop && tx_cnt_r != 0);
         if (wr_acc && paddr == asf_pkg::ASF_OFF_CONFIG && pwdata[17]) rx_cnt_r <= '0;
         else rx_cnt_r <= rx_cnt_r + CNT_W'(rx_push && (rx_cnt_r != DEPTH || rx_pop))
                                   - CNT_W'(rx_pop && rx_cnt_r != 0);
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   tx_dma_room_a: assert property (tx_dma_req |-> tx_cnt_r != DEPTH)
      else $error("tx dma request while fifo full");
   rx_dma_data_a: assert property (rx_dma_req |-> rx_cnt_r != 0)
      else $error("rx dma request while fifo empty");
   level_read_a: assert property (rd_st |-> prdata[12:8] == $past(tx_cnt_r)
      && prdata[20:16] == $past(rx_cnt_r)) else $error("status level fields wrong");
   tx_flags_a: assert property (rd_st |-> prdata[4] == (prdata[12:8] == 0)
      && prdata[5] == (prdata[12:8] != DEPTH)) else $error("tx flags disagree with level");
   rx_flags_a: assert property (rd_st |-> prdata[6] == (prdata[20:16] != 0)
      && prdata[7] == (prdata[20:16] == DEPTH)) else $error("rx flags disagree with level");
   periph_bit_a: assert property (rd_st |-> prdata[3] == $past(periph_irq))
      else $error("peripheral status bit wrong");
   periph_irq_a: assert property (periph_irq |-> ##[0:1] fifo_irq)
      else $error("peripheral request not forwarded");
   wake_cause_a: assert property (wake_req |-> tx_level_trig || rx_level_trig)
      else $error("wake without level trigger");
   tx_trig_a: assert property (tx_level_trig |-> trig_r[0] && tx_cnt_r <= trig_r[11:8])
      else $error("tx trigger without cause");
   rx_trig_a: assert property (rx_level_trig |-> trig_r[1] && rx_cnt_r > trig_r[19:16])
      else $error("rx trigger without cause");
endmodule : asf_fifo_status_props
bind asf_fifo_status asf_fifo_status_props #(.DEPTH(DEPTH), .CNT_W(CNT_W)) i_asf_fifo_status_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_push(tx_push), .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop),
   .periph_irq(periph_irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
   .tx_level_trig(tx_level_trig), .rx_level_trig(rx_level_trig), .fifo_irq(fifo_irq),
   .wake_req(wake_req));
`default_nettype wire

// File: verification/asf_periph_model.sv
// peripheral-side model: takes tx data, delivers rx data, raises its irq
`timescale 1ns/1ps
`default_nettype none
module asf_periph_model (
   input wire logic pclk,
   output logic     tx_pop,
   output logic     rx_push,
   output logic     periph_irq
);
   initial begin
      tx_pop     = 1'b0;
      rx_push    = 1'b0;
      periph_irq = 1'b0;
   end
   // ==========================================================
   // one pulse per item, may ask for data from an empty fifo
   task automatic move(input logic pop, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (pop) tx_pop <= 1'b1;
         else rx_push <= 1'b1;
         @(posedge pclk);
         tx_pop  <= 1'b0;
         rx_push <= 1'b0;
      end
      @(negedge pclk);
   endtask : move
   task automatic set_irq(input logic v);
      @(posedge pclk);
      periph_irq <= v;
      @(negedge pclk);
   endtask : set_irq
endmodule : asf_periph_model
`default_nettype wire

// File: verification/audio_serial_fifo_status_trigger_test.sv
// self-checking testbench for the fifo status block
`timescale 1ns/1ps
`default_nettype none
module audio_serial_fifo_status_trigger_test;
   localparam logic [11:0] CF = asf_pkg::ASF_OFF_CONFIG;
   localparam logic [11:0] ST = asf_pkg::ASF_OFF_STATUS;
   localparam logic [11:0] TG = asf_pkg::ASF_OFF_TRIGGER;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
   logic        tx_push, tx_pop, rx_push, rx_pop, periph_irq, tx_dma_req, rx_dma_req;
   logic        tx_level_trig, rx_level_trig, fifo_irq, wake_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   int          err_count, checks, cyc;
   asf_fifo_status i_asf_fifo_status (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_push(tx_push), .tx_pop(tx_pop),
      .rx_push(rx_push), .rx_pop(rx_pop), .periph_irq(periph_irq), .tx_dma_req(tx_dma_req),
      .rx_dma_req(rx_dma_req), .tx_level_trig(tx_level_trig), .rx_level_trig(rx_level_trig),
      .fifo_irq(fifo_irq), .wake_req(wake_req));
   asf_periph_model i_asf_periph_model (.pclk(pclk), .tx_pop(tx_pop), .rx_push(rx_push),
      .periph_irq(periph_irq));
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chb
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_q = prdata;
      rd_e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic sw(input logic rx, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (rx) rx_pop <= 1'b1;
         else tx_push <= 1'b1;
         @(posedge pclk);
         rx_pop  <= 1'b0;
         tx_push <= 1'b0;
      end
      @(negedge pclk);
   endtask : sw
   task automatic st_is(input logic [4:0] tx, input logic [4:0] rx, input logic [3:0] f);
      apb(1'b0, ST, 32'h0000_0000);
      chk(rd_q, {11'h000, rx, 3'h0, tx, rx == 5'h08, rx != 5'h00, tx != 5'h08, tx == 5'h00, f});
      @(negedge pclk);
   endtask : st_is
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   // ==========================================================
   // scenarios
   task automatic t_tx();
      st_is(5'h00, 5'h00, 4'h0);
      apb(1'b1, CF, 32'h0000_1000);
      @(negedge pclk);
      chb(tx_dma_req, 1'b1);
      sw(1'b0, 8);
      st_is(5'h08, 5'h00, 4'h0);
      chb(tx_dma_req, 1'b0);
      sw(1'b0, 1);
      st_is(5'h08, 5'h00, 4'h1);
      apb(1'b1, ST, 32'h0000_0001);
      st_is(5'h08, 5'h00, 4'h0);
      fork
         apb(1'b1, ST, 32'h0000_0001);
         begin
            @(posedge pclk);
            sw(1'b0, 1);
         end
      join
      st_is(5'h08, 5'h00, 4'h1);
      apb(1'b1, ST, 32'h0000_0001);
      i_asf_periph_model.move(1'b1, 9);
      st_is(5'h00, 5'h00, 4'h1);
      apb(1'b1, ST, 32'h0000_0001);
      $display("test tx done");
   endtask : t_tx
   task automatic t_rx();
      apb(1'b1, CF, 32'h0000_3000);
      i_asf_periph_model.move(1'b0, 8);
      st_is(5'h00, 5'h08, 4'h0);
      chb(rx_dma_req, 1'b1);
      i_asf_periph_model.move(1'b0, 1);
      st_is(5'h00, 5'h08, 4'h2);
      sw(1'b1, 8);
      chb(rx_dma_req, 1'b0);
      apb(1'b1, ST, 32'h0000_0002);
      st_is(5'h00, 5'h00, 4'h0);
      $display("test rx done");
   endtask : t_rx
   task automatic t_trig();
      apb(1'b1, asf_pkg::ASF_OFF_IRQ_SET, 32'h0000_000C);
      apb(1'b1, CF, 32'h0000_7000);
      apb(1'b1, TG, 32'h0003_0200);
      sw(1'b0, 4);
      i_asf_periph_model.move(1'b1, 2);
      chb(tx_level_trig, 1'b0);
      apb(1'b1, TG, 32'h0003_0203);
      sw(1'b0, 1);
      i_asf_periph_model.move(1'b1, 1);
      chb(tx_level_trig, 1'b1);
      chb(fifo_irq, 1'b1);
      chb(wake_req, 1'b1);
      chb(tx_dma_req, 1'b1);
      i_asf_periph_model.move(1'b0, 3);
      chb(rx_level_trig, 1'b0);
      i_asf_periph_model.move(1'b0, 1);
      chb(rx_level_trig, 1'b1);
      apb(1'b1, TG, 32'h0000_0000);
      @(negedge pclk);
      chb(tx_level_trig, 1'b0);
      chb(rx_level_trig, 1'b0);
      chb(fifo_irq, 1'b0);
      apb(1'b1, CF, 32'h0003_0000);
      st_is(5'h00, 5'h00, 4'h0);
      $display("test trigger done");
   endtask : t_trig
   task automatic t_misc();
      i_asf_periph_model.set_irq(1'b1);
      st_is(5'h00, 5'h00, 4'h8);
      chb(fifo_irq, 1'b1);
      i_asf_periph_model.set_irq(1'b0);
      repeat (2) @(negedge pclk);
      chb(fifo_irq, 1'b0);
      apb(1'b0, 12'hE0C, 32'h0000_0000);
      chk(rd_q, 32'h0000_0000);
      chb(rd_e, 1'b1);
      $display("test misc done");
   endtask : t_misc
   // ==========================================================
   // clock, timeout, main sequence
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, tx_push, rx_pop} = 7'h00;
      paddr  = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_tx();
      t_rx();
      t_trig();
      t_misc();
      test_done();
   end
endmodule : audio_serial_fifo_status_trigger_test
`default_nettype wire
